// File: logic/pmt_top.sv
// Program store, program counter, table read path and serial programming link
// How it works
// RULE1 - Store of 16-bit words, 2K or 4K deep
// RULE2 - Reset loads program counter with word zero
// RULE3 - Table address from low and high pointers
// RULE4 - Table read low byte goes to destination
// RULE5 - Table read high byte goes to holding
// RULE6 - Holding bits without stored bits read zero
// RULE7 - Page read: low pointer offsets current page
// RULE8 - Holding register changes only by table reads
// RULE9 - Every table read takes two cycles
// RULE10 - Serial link programs flash and data store
// RULE11 - One bidirectional data pin, programmer clock
// RULE12 - Debug data bidirectional, debug clock input
// RULE13 - Emulation variant disables shared pin functions
// RULE14 - Debug pins still serve serial programming
// RULE15 - A page spans 256 words
// RULE16 - Last-page read offsets the final page
// RULE17 - Link framing here is a local choice
`timescale 1ns/1ns
`default_nettype none
module pmt_top #(
    parameter bit big_variant = 1'b1,
    parameter bit emu_variant = 1'b0
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Instruction fetch
    input wire logic cpu_step,
    input wire logic cpu_jump,
    input wire logic [11:0] cpu_jump_addr,
    output logic [11:0] pc_out,
    output logic [15:0] instr_word,
    // Table pointer writes
    input wire logic tblp_wr,
    input wire logic tbhp_wr,
    input wire logic [7:0] tbl_wr_data,
    // Table read request
    input wire logic tab_start,
    input wire logic [1:0] tab_mode,
    input wire logic [7:0] tab_dest,
    output logic tab_busy,
    // Data memory write of the low byte, and the high byte holding register
    output logic dmem_wr_en,
    output logic [7:0] dmem_wr_addr,
    output logic [7:0] dmem_wr_data,
    output logic [7:0] table_high_holding,
    // Data EEPROM side of the serial link
    input wire logic [7:0] ee_rd_data,
    output logic ee_wr_en,
    output logic [11:0] ee_wr_addr,
    output logic [7:0] ee_wr_data,
    // Enable of other functions sharing the serial pins
    output logic shared_func_enable,
    // Serial programming and debug link
    input wire logic prog_serial_clock,
    input wire logic prog_select,
    input wire logic prog_serial_data_in,
    output logic prog_serial_data_out,
    output logic prog_serial_data_oe
);
    localparam logic [11:0] ADDR_MASK = big_variant ? pmt_pkg::PMT_MASK_BIG : pmt_pkg::PMT_MASK_SMALL;
    localparam logic [3:0] LAST_PAGE = big_variant ? pmt_pkg::PMT_LAST_PAGE_BIG : pmt_pkg::PMT_LAST_PAGE_SMALL;

    // Program store array, written only by the serial link
    logic [pmt_pkg::PMT_WORD_W-1:0] mem [pmt_pkg::PMT_DEPTH];

    // Core domain state
    logic [11:0] pc_reg, pc_next;
    logic [15:0] instr_reg;
    logic [7:0] tblp_reg, tblp_next;
    logic [7:0] tbhp_reg, tbhp_next;
    pmt_pkg::pmt_tab_state_e tab_state_reg, tab_state_next;
    logic [11:0] tab_addr_reg, tab_addr_next;
    logic [7:0] tab_dest_reg, tab_dest_next;
    logic [15:0] tab_word_reg;
    logic tab_busy_reg, tab_busy_next;
    logic dmem_wr_en_reg, dmem_wr_en_next;
    logic [7:0] dmem_wr_addr_reg, dmem_wr_addr_next;
    logic [7:0] dmem_wr_data_reg, dmem_wr_data_next;
    logic [7:0] high_reg, high_next;
    logic req_seen_reg, req_seen_next;
    logic ack_tgl_reg, ack_tgl_next;
    logic [15:0] rd_word_reg, rd_word_next;
    logic mem_we;
    logic ee_wr_en_reg, ee_wr_en_next;
    logic [11:0] ee_wr_addr_reg, ee_wr_addr_next;
    logic [7:0] ee_wr_data_reg, ee_wr_data_next;
    logic shared_en_reg, shared_en_next;
    logic [1:0] core_sync;
    logic select_core, req_core;

    // Link domain state
    logic [5:0] cnt_reg, cnt_next;
    logic [13:0] hdr_reg, hdr_next;
    logic [15:0] wdata_reg, wdata_next;
    logic req_tgl_reg, req_tgl_next;
    logic [15:0] out_shift_reg, out_shift_next;
    logic sd_out_reg, sd_out_next;
    logic sd_oe_reg, sd_oe_next;
    logic [1:0] link_sync;
    logic rst_link, ack_link;

    // Link signals into the core domain; header and data are held stable until acknowledged
    pmt_sync #(.W(2)) u_core_sync (
        .clk(core_clk),
        .async_in({prog_select, req_tgl_reg}),
        .sync_out(core_sync)
    );
    assign select_core = core_sync[1];
    assign req_core = core_sync[0];

    // Reset and acknowledge into the link domain
    pmt_sync #(.W(2)) u_link_sync (
        .clk(prog_serial_clock),
        .async_in({rst, ack_tgl_reg}),
        .sync_out(link_sync)
    );
    assign rst_link = link_sync[1];
    assign ack_link = link_sync[0];

    // Program counter and pointer registers
    always_comb begin
        pc_next = pc_reg;
        tblp_next = tblp_reg;
        tbhp_next = tbhp_reg;
        if (cpu_jump) begin
            pc_next = cpu_jump_addr & ADDR_MASK; // RULE1
        end else if (cpu_step) begin
            pc_next = (pc_reg + 12'h001) & ADDR_MASK; // RULE1
        end
        if (tblp_wr) begin
            tblp_next = tbl_wr_data; // RULE3
        end
        if (tbhp_wr) begin
            tbhp_next = tbl_wr_data; // RULE3
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_reg <= pmt_pkg::PMT_RESET_VECTOR; // RULE2
            tblp_reg <= 8'h00;
            tbhp_reg <= 8'h00;
        end else begin
            pc_reg <= pc_next;
            tblp_reg <= tblp_next;
            tbhp_reg <= tbhp_next;
        end
    end

    // Table read sequencer: start, fetch word, deliver both bytes
    always_comb begin
        tab_state_next = tab_state_reg;
        tab_addr_next = tab_addr_reg;
        tab_dest_next = tab_dest_reg;
        tab_busy_next = 1'b0;
        dmem_wr_en_next = 1'b0;
        dmem_wr_addr_next = dmem_wr_addr_reg;
        dmem_wr_data_next = dmem_wr_data_reg;
        high_next = high_reg;
        unique case (tab_state_reg)
            pmt_pkg::PMT_TAB_IDLE: begin
                if (tab_start) begin
                    tab_state_next = pmt_pkg::PMT_TAB_FETCH;
                    tab_busy_next = 1'b1; // RULE9
                    tab_dest_next = tab_dest;
                    if (tab_mode == pmt_pkg::PMT_TAB_MODE_PAGE) begin
                        tab_addr_next = {pc_reg[11:pmt_pkg::PMT_PAGE_LSB], tblp_reg}; // RULE7 RULE15
                    end else if (tab_mode == pmt_pkg::PMT_TAB_MODE_LAST) begin
                        tab_addr_next = {LAST_PAGE, tblp_reg}; // RULE16
                    end else begin
                        tab_addr_next = {tbhp_reg[3:0], tblp_reg} & ADDR_MASK; // RULE3
                    end
                end
            end
            pmt_pkg::PMT_TAB_FETCH: begin
                tab_state_next = pmt_pkg::PMT_TAB_STORE;
                tab_busy_next = 1'b1; // RULE9
            end
            pmt_pkg::PMT_TAB_STORE: begin
                tab_state_next = pmt_pkg::PMT_TAB_IDLE;
                dmem_wr_en_next = 1'b1; // RULE4
                dmem_wr_addr_next = tab_dest_reg; // RULE4
                dmem_wr_data_next = tab_word_reg[7:0]; // RULE4
                // Only a table read reaches the holding register; there is no write path
                high_next = 8'(tab_word_reg[pmt_pkg::PMT_WORD_W-1:8]); // RULE5 RULE6 RULE8
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tab_state_reg <= pmt_pkg::PMT_TAB_IDLE;
            tab_addr_reg <= 12'h000;
            tab_dest_reg <= 8'h00;
            tab_busy_reg <= 1'b0;
            dmem_wr_en_reg <= 1'b0;
            dmem_wr_addr_reg <= 8'h00;
            dmem_wr_data_reg <= 8'h00;
            high_reg <= 8'h00;
        end else begin
            tab_state_reg <= tab_state_next;
            tab_addr_reg <= tab_addr_next;
            tab_dest_reg <= tab_dest_next;
            tab_busy_reg <= tab_busy_next;
            dmem_wr_en_reg <= dmem_wr_en_next;
            dmem_wr_addr_reg <= dmem_wr_addr_next;
            dmem_wr_data_reg <= dmem_wr_data_next;
            high_reg <= high_next;
        end
    end

    // Link requests seen in the core: program or EEPROM access, then acknowledge
    always_comb begin
        req_seen_next = req_core;
        ack_tgl_next = ack_tgl_reg;
        rd_word_next = rd_word_reg;
        mem_we = 1'b0;
        ee_wr_en_next = 1'b0;
        ee_wr_addr_next = ee_wr_addr_reg;
        ee_wr_data_next = ee_wr_data_reg;
        shared_en_next = !emu_variant && !select_core; // RULE13
        if (req_core != req_seen_reg) begin
            ack_tgl_next = !ack_tgl_reg;
            if (hdr_reg[pmt_pkg::PMT_HDR_OP]) begin
                if (hdr_reg[pmt_pkg::PMT_HDR_TGT]) begin
                    ee_wr_en_next = 1'b1; // RULE10
                    ee_wr_addr_next = hdr_reg[11:0];
                    ee_wr_data_next = wdata_reg[7:0];
                end else begin
                    mem_we = 1'b1; // RULE10
                end
            end else if (hdr_reg[pmt_pkg::PMT_HDR_TGT]) begin
                rd_word_next = {8'h00, ee_rd_data};
            end else begin
                rd_word_next = mem[hdr_reg[11:0] & ADDR_MASK];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_seen_reg <= 1'b0;
            ack_tgl_reg <= 1'b0;
            rd_word_reg <= 16'h0000;
            ee_wr_en_reg <= 1'b0;
            ee_wr_addr_reg <= 12'h000;
            ee_wr_data_reg <= 8'h00;
            shared_en_reg <= 1'b0;
        end else begin
            req_seen_reg <= req_seen_next;
            ack_tgl_reg <= ack_tgl_next;
            rd_word_reg <= rd_word_next;
            ee_wr_en_reg <= ee_wr_en_next;
            ee_wr_addr_reg <= ee_wr_addr_next;
            ee_wr_data_reg <= ee_wr_data_next;
            shared_en_reg <= shared_en_next;
        end
    end

    // Store array ports: one write from the link, fetch and table reads
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[hdr_reg[11:0] & ADDR_MASK] <= wdata_reg; // RULE1
        end
        instr_reg <= mem[pc_reg]; // RULE1 RULE2
        tab_word_reg <= mem[tab_addr_reg];
    end

    // Link frame: header, then write data or turnaround and read data
    always_comb begin
        cnt_next = cnt_reg;
        hdr_next = hdr_reg;
        wdata_next = wdata_reg;
        req_tgl_next = req_tgl_reg;
        out_shift_next = out_shift_reg;
        sd_out_next = 1'b0;
        sd_oe_next = 1'b0;
        if (!prog_select) begin
            cnt_next = 6'h00;
        end else begin
            if (cnt_reg != pmt_pkg::PMT_CNT_MAX) begin
                cnt_next = cnt_reg + 6'h01;
            end
            if (cnt_reg <= pmt_pkg::PMT_HDR_LAST) begin
                hdr_next = {hdr_reg[12:0], prog_serial_data_in}; // RULE11
            end
            if (cnt_reg == pmt_pkg::PMT_HDR_LAST && !hdr_reg[pmt_pkg::PMT_HDR_OP - 1]) begin
                req_tgl_next = !req_tgl_reg; // RULE11
            end
            if (hdr_reg[pmt_pkg::PMT_HDR_OP] && cnt_reg > pmt_pkg::PMT_HDR_LAST) begin
                if (cnt_reg <= pmt_pkg::PMT_WR_LAST) begin
                    wdata_next = {wdata_reg[14:0], prog_serial_data_in}; // RULE10
                end
                if (cnt_reg == pmt_pkg::PMT_WR_LAST) begin
                    req_tgl_next = !req_tgl_reg; // RULE10
                end
            end else if (!hdr_reg[pmt_pkg::PMT_HDR_OP] && cnt_reg >= pmt_pkg::PMT_RD_LAUNCH
                         && cnt_reg < pmt_pkg::PMT_RD_END) begin
                // The word is only taken once the core has answered; a late answer reads as zero
                if (cnt_reg == pmt_pkg::PMT_RD_LAUNCH) begin
                    out_shift_next = (ack_link == req_tgl_reg) ? rd_word_reg : 16'h0000;
                    sd_out_next = (ack_link == req_tgl_reg) ? rd_word_reg[15] : 1'b0; // RULE11 RULE12
                    out_shift_next = {out_shift_next[14:0], 1'b0};
                end else begin
                    sd_out_next = out_shift_reg[15]; // RULE11 RULE12
                    out_shift_next = {out_shift_reg[14:0], 1'b0};
                end
                sd_oe_next = 1'b1; // RULE12 RULE14
            end
        end
    end

    always_ff @(posedge prog_serial_clock) begin
        if (rst_link) begin
            cnt_reg <= 6'h00;
            hdr_reg <= 14'h0000;
            wdata_reg <= 16'h0000;
            req_tgl_reg <= 1'b0;
            out_shift_reg <= 16'h0000;
            sd_out_reg <= 1'b0;
            sd_oe_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            hdr_reg <= hdr_next;
            wdata_reg <= wdata_next;
            req_tgl_reg <= req_tgl_next;
            out_shift_reg <= out_shift_next;
            sd_out_reg <= sd_out_next;
            sd_oe_reg <= sd_oe_next;
        end
    end

    // Outputs straight from flip-flops
    assign pc_out = pc_reg;
    assign instr_word = instr_reg;
    assign tab_busy = tab_busy_reg;
    assign dmem_wr_en = dmem_wr_en_reg;
    assign dmem_wr_addr = dmem_wr_addr_reg;
    assign dmem_wr_data = dmem_wr_data_reg;
    assign table_high_holding = high_reg;
    assign ee_wr_en = ee_wr_en_reg;
    assign ee_wr_addr = ee_wr_addr_reg;
    assign ee_wr_data = ee_wr_data_reg;
    assign shared_func_enable = shared_en_reg;
    assign prog_serial_data_out = sd_out_reg;
    assign prog_serial_data_oe = sd_oe_reg;

    // Checks on the core side
    sequence s_tab_accept;
        tab_start && tab_state_reg == pmt_pkg::PMT_TAB_IDLE;
    endsequence

    sequence s_tab_deliver;
        tab_busy_reg [*2] ##1 (!tab_busy_reg && dmem_wr_en_reg);
    endsequence

    a_pc_reset_vector: assert property (@(posedge core_clk) rst |=> pc_reg == 12'h000) // RULE2
        else $error("program counter not at zero after reset");

    a_tab_two_cycles: assert property (@(posedge core_clk) disable iff (rst)
        s_tab_accept |=> s_tab_deliver) // RULE9
        else $error("table read did not finish in two cycles");

    a_tab_low_byte: assert property (@(posedge core_clk) disable iff (rst)
        dmem_wr_en_reg |-> dmem_wr_data_reg == tab_word_reg[7:0] && dmem_wr_addr_reg == tab_dest_reg) // RULE4
        else $error("low byte or destination wrong");

    a_tab_high_byte: assert property (@(posedge core_clk) disable iff (rst)
        dmem_wr_en_reg |-> table_high_holding == tab_word_reg[15:8]) // RULE5 RULE6
        else $error("high byte not in holding register");

    a_high_only_table: assert property (@(posedge core_clk) disable iff (rst)
        !$stable(high_reg) |-> $past(tab_state_reg) == pmt_pkg::PMT_TAB_STORE) // RULE8
        else $error("holding register changed outside a table read");

    a_page_address: assert property (@(posedge core_clk) disable iff (rst)
        s_tab_accept and tab_mode == pmt_pkg::PMT_TAB_MODE_PAGE
        |=> tab_addr_reg == {$past(pc_reg[11:8]), $past(tblp_reg)}) // RULE7 RULE15
        else $error("current page address wrong");

    a_last_address: assert property (@(posedge core_clk) disable iff (rst)
        s_tab_accept and tab_mode == pmt_pkg::PMT_TAB_MODE_LAST
        |=> tab_addr_reg == {LAST_PAGE, $past(tblp_reg)}) // RULE16
        else $error("last page address wrong");

    a_full_address: assert property (@(posedge core_clk) disable iff (rst)
        s_tab_accept and tab_mode == pmt_pkg::PMT_TAB_MODE_FULL
        |=> tab_addr_reg == ({$past(tbhp_reg[3:0]), $past(tblp_reg)} & ADDR_MASK)) // RULE3
        else $error("full pointer address wrong");

    a_shared_off: assert property (@(posedge core_clk) disable iff (rst)
        emu_variant |=> !shared_func_enable) // RULE13
        else $error("shared pin function active on emulation variant");

    a_pc_in_range: assert property (@(posedge core_clk) disable iff (rst)
        (pc_reg & ~ADDR_MASK) == 12'h000) // RULE1
        else $error("program counter beyond store size");

    // Check on the link side
    a_link_drive: assert property (@(posedge prog_serial_clock) disable iff (rst_link || !prog_select)
        sd_oe_reg |-> !hdr_reg[pmt_pkg::PMT_HDR_OP] && cnt_reg > pmt_pkg::PMT_RD_LAUNCH) // RULE11 RULE14
        else $error("data pin driven outside read window");
endmodule
`default_nettype wire

// File: logic/pmt_pkg.sv
// Constants and types shared by the program memory and table read block
package pmt_pkg;
    // Program store geometry
    localparam int PMT_WORD_W = 16;
    localparam int PMT_ADDR_W = 12;
    localparam int PMT_DEPTH = 4096;
    localparam logic [11:0] PMT_MASK_SMALL = 12'h7ff;
    localparam logic [11:0] PMT_MASK_BIG = 12'hfff;
    localparam logic [11:0] PMT_RESET_VECTOR = 12'h000;
    // Pages of 256 words: upper address bits select the page
    localparam int PMT_PAGE_LSB = 8;
    localparam logic [3:0] PMT_LAST_PAGE_SMALL = 4'h7;
    localparam logic [3:0] PMT_LAST_PAGE_BIG = 4'hf;
    // Table read address modes
    localparam logic [1:0] PMT_TAB_MODE_FULL = 2'h0;
    localparam logic [1:0] PMT_TAB_MODE_PAGE = 2'h1;
    localparam logic [1:0] PMT_TAB_MODE_LAST = 2'h2;
    // Table read sequencer
    typedef enum logic [1:0] {PMT_TAB_IDLE, PMT_TAB_FETCH, PMT_TAB_STORE} pmt_tab_state_e;
    // Serial frame bit positions, counted in link clock edges
    localparam logic [5:0] PMT_HDR_LAST = 6'h0d;
    localparam logic [5:0] PMT_WR_LAST = 6'h1d;
    localparam logic [5:0] PMT_RD_LAUNCH = 6'h15;
    localparam logic [5:0] PMT_RD_END = 6'h25;
    localparam logic [5:0] PMT_CNT_MAX = 6'h3f;
    // Header bit positions once all header bits are in
    localparam int PMT_HDR_OP = 13;
    localparam int PMT_HDR_TGT = 12;
endpackage

// File: logic/pmt_sync.sv
// Two flip-flop level synchroniser, one lane per bit
`timescale 1ns/1ns
`default_nettype none
module pmt_sync #(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clk,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // No reset: the chain flushes within two edges of any clock
    always_ff @(posedge clk) begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// File: sim/pmt_programmer.sv
// Model of the external programmer that drives the serial link
`timescale 1ns/1ns
`default_nettype none
module pmt_programmer (
    // Link pins
    output logic link_clk,
    output logic link_sel,
    output logic link_line,
    input wire logic dev_out,
    input wire logic dev_oe
);
    logic drv_en = 1'b0;
    logic drv_bit = 1'b0;
    logic idle_bit = 1'b0;
    initial begin
        link_clk = 1'b0;
        link_sel = 1'b0;
    end
    // Device wins while it drives; a released line shows a changing pattern, not the last bit
    assign link_line = dev_oe ? dev_out : (drv_en ? drv_bit : idle_bit);
    // One link period; the clock stands still between calls
    task automatic pulse();
        #24 link_clk = 1'b1;
        #24 link_clk = 1'b0;
        idle_bit = ~idle_bit;
    endtask
    // Clock with select low, line released
    task automatic idle(input int n);
        link_sel = 1'b0;
        drv_en = 1'b0;
        repeat (n) pulse();
    endtask
    // Header, then write data or turnaround and read data, MSB first
    task automatic frame(input logic wr, input logic tgt, input logic [11:0] a, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [29:0] bits;
        bits = {wr, tgt, a, wd};
        rd = 16'h0000;
        idle(1);
        link_sel = 1'b1;
        drv_en = 1'b1;
        for (int k = 0; k < 38; k++) begin
            // Bits change with the clock low, so the rising edge sees them settled
            if (!wr && k >= 22) rd[37-k] = link_line;
            if (k < 14 || (wr && k < 30)) drv_bit = bits[29-k];
            else drv_en = 1'b0;
            pulse();
        end
        idle(5);
    endtask
endmodule
`default_nettype wire

// File: sim/program_memory_table_read_bench.sv
// Self-checking bench for the program memory and table read block
`timescale 1ns/1ns
`default_nettype none
module program_memory_table_read_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cpu_step = 1'b0;
    logic cpu_jump = 1'b0;
    logic [11:0] cpu_jump_addr = 12'h000;
    logic tblp_wr = 1'b0;
    logic tbhp_wr = 1'b0;
    logic [7:0] tbl_wr_data = 8'h00;
    logic tab_start = 1'b0;
    logic [1:0] tab_mode = 2'h0;
    logic [7:0] tab_dest = 8'h00;
    logic [7:0] ee_rd_data = 8'h3c;
    logic prog_serial_clock, prog_select, prog_serial_data_in;
    logic [11:0] pc_out, ee_wr_addr, ee_a;
    logic [15:0] instr_word;
    logic tab_busy, dmem_wr_en, ee_wr_en, shared_func_enable, prog_serial_data_out, prog_serial_data_oe;
    logic [7:0] dmem_wr_addr, dmem_wr_data, table_high_holding, ee_wr_data, ee_d;
    logic ee_seen = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    logic [11:0] addrs [6] = '{12'h000, 12'h001, 12'hfff, 12'h305, 12'hf06, 12'h5a7};

    pmt_top #(.big_variant(1'b1), .emu_variant(1'b0)) pmt_top_inst (.core_clk, .rst, .cpu_step,
        .cpu_jump, .cpu_jump_addr, .pc_out, .instr_word, .tblp_wr, .tbhp_wr, .tbl_wr_data, .tab_start,
        .tab_mode, .tab_dest, .tab_busy, .dmem_wr_en, .dmem_wr_addr, .dmem_wr_data, .table_high_holding,
        .ee_rd_data, .ee_wr_en, .ee_wr_addr, .ee_wr_data, .shared_func_enable, .prog_serial_clock,
        .prog_select, .prog_serial_data_in, .prog_serial_data_out, .prog_serial_data_oe);
    pmt_programmer pmt_programmer_inst (.link_clk(prog_serial_clock), .link_sel(prog_select),
        .link_line(prog_serial_data_in), .dev_out(prog_serial_data_out), .dev_oe(prog_serial_data_oe));

    always #25 core_clk = ~core_clk;
    // Latch the one-cycle EEPROM write pulse so a slow check cannot miss it
    always @(posedge core_clk) begin
        if (ee_wr_en === 1'b1) begin
            ee_seen <= 1'b1;
            ee_a <= ee_wr_addr;
            ee_d <= ee_wr_data;
        end
    end
    // Stored pattern: low and high bytes differ for every address used
    function automatic logic [15:0] word(input logic [11:0] a);
        return {a[7:0] ^ 8'hc3, a[11:4]};
    endfunction
    task automatic cyc();
        @(posedge core_clk);
        #5;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_reset();
        chk("pc", 16'h0000, 16'(pc_out));
        chk("busy", 16'h0000, 16'(tab_busy));
        cyc();
        chk("shared", 16'h0001, 16'(shared_func_enable));
        $display("reset test done");
    endtask
    task automatic t_program();
        logic [15:0] rd;
        // Link-side reset only lets go after two link edges with the core reset low
        pmt_programmer_inst.idle(2);
        foreach (addrs[i]) pmt_programmer_inst.frame(1'b1, 1'b0, addrs[i], word(addrs[i]), rd);
        chk("ee_quiet", 16'h0000, 16'(ee_seen));
        pmt_programmer_inst.frame(1'b1, 1'b1, 12'h2a5, 16'h00c7, rd);
        chk("ee_seen", 16'h0001, 16'(ee_seen));
        chk("ee_addr", 16'h02a5, 16'(ee_a));
        chk("ee_data", 16'h00c7, 16'(ee_d));
        pmt_programmer_inst.frame(1'b0, 1'b0, 12'hf06, 16'h0000, rd);
        chk("read_back", word(12'hf06), rd);
        pmt_programmer_inst.frame(1'b0, 1'b1, 12'h2a5, 16'h0000, rd);
        chk("ee_read", {8'h00, ee_rd_data}, rd);
        $display("serial link test done");
    endtask
    // Fetch across the top of the 4K store wraps to word zero
    task automatic t_fetch();
        cpu_jump_addr = 12'hfff;
        cpu_jump = 1'b1;
        cyc();
        cpu_jump = 1'b0;
        cpu_step = 1'b1;
        chk("pc_top", 16'h0fff, 16'(pc_out));
        cyc();
        chk("pc_wrap", 16'h0000, 16'(pc_out));
        cyc();
        cpu_step = 1'b0;
        chk("pc_one", 16'h0001, 16'(pc_out));
        cyc();
        chk("instr", word(12'h001), instr_word);
        $display("fetch test done");
    endtask
    task automatic setp(input logic [7:0] lo, input logic [7:0] hi);
        tblp_wr = 1'b1;
        tbl_wr_data = lo;
        cyc();
        tblp_wr = 1'b0;
        tbhp_wr = 1'b1;
        tbl_wr_data = hi;
        cyc();
        tbhp_wr = 1'b0;
    endtask
    // Start held through the first busy cycle must be ignored; dest is taken with the start
    task automatic rd_tab(input logic [1:0] m, input logic [11:0] a);
        logic [15:0] w;
        w = word(a);
        tab_start = 1'b1;
        tab_mode = m;
        tab_dest = a[7:0] ^ 8'h11;
        cyc();
        tab_dest = 8'h00;
        chk("busy1", 16'h0001, 16'(tab_busy));
        cyc();
        tab_start = 1'b0;
        chk("busy2", 16'h0001, 16'(tab_busy));
        cyc();
        chk("wr_en", 16'h0001, 16'(dmem_wr_en));
        chk("dest", 16'(a[7:0] ^ 8'h11), 16'(dmem_wr_addr));
        chk("low", 16'(w[7:0]), 16'(dmem_wr_data));
        chk("high", 16'(w[15:8]), 16'(table_high_holding));
        cyc();
        chk("wr_end", 16'h0000, 16'(dmem_wr_en));
        $display("table read mode %0d done", m);
    endtask
    task automatic t_table();
        setp(8'ha7, 8'h05);
        rd_tab(2'h0, 12'h5a7);
        rd_tab(2'h3, 12'h5a7);
        setp(8'h05, 8'h05);
        cpu_jump_addr = 12'h312;
        cpu_jump = 1'b1;
        cyc();
        cpu_jump = 1'b0;
        rd_tab(2'h1, 12'h305);
        setp(8'h06, 8'h05);
        rd_tab(2'h2, 12'hf06);
        setp(8'hff, 8'hff);
        chk("hold_kept", 16'(word(12'hf06) >> 8), 16'(table_high_holding));
        $display("table test done");
    endtask
    // Hang guard, well beyond the expected run of some 21 us
    initial begin
        #2_000_000;
        num_errors++;
        end_of_test();
    end
    initial begin
        fork
            pmt_programmer_inst.idle(6);
            repeat (12) @(posedge core_clk);
        join
        #5 rst = 1'b0;
        t_reset();
        t_program();
        t_fetch();
        t_table();
        end_of_test();
    end
endmodule
`default_nettype wire
